/* src/ext_bus_ready_pkg.sv */
// Function
// - External ready stretches the running bus cycle
// - Ready active level is selectable high or low
// - Synchronous mode gives shortest cycle, clock-aligned input
// - Asynchronous mode adds sync stage, one wait
// - First sample point follows programmed phase lengths
// - Inactive sample inserts one more ready wait
// - Active sample terminates the running bus cycle
// - Asynchronous sample point later than synchronous one
// - Ready ignored until mandatory access waits elapse
// - Read data captured on strobe-release edge
package ext_bus_ready_pkg;

	// ==========================================================
	// Widths and limits
	localparam int ACC_LEN_W = 6;
	localparam logic [ACC_LEN_W-1:0] ACC_LEN_MIN = 6'h01;
	localparam logic [ACC_LEN_W-1:0] ACC_LEN_MAX = 6'h20;
	localparam int ADDR_W_DEF = 24;
	localparam int DATA_W_DEF = 16;

	// ==========================================================
	// Reset values
	localparam logic RST_STROBE_B = 1'b1;
	localparam logic RST_REF_CLK = 1'b0;
	localparam logic RST_POL = 1'b1;
	localparam logic RST_ASYNC = 1'b0;

	// ==========================================================
	// Bus cycle states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_ACCESS = 3'h2,
		ST_RDY_WAIT = 3'h4
	} cycle_state_t;

endpackage

/* src/ext_bus_ready_wait_control.sv */
`timescale 1ns/1ps
module ext_bus_ready_wait_control #(
	parameter int ADDR_W = ext_bus_ready_pkg::ADDR_W_DEF,
	parameter int DATA_W = ext_bus_ready_pkg::DATA_W_DEF
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire logic write_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic [ext_bus_ready_pkg::ACC_LEN_W-1:0] access_phase_length_i,
	input wire logic ready_async_i,
	input wire logic ready_active_high_i,
	input wire logic ready_i,
	input wire logic [DATA_W-1:0] data_pin_i,
	output logic req_ready_o,
	output logic busy_o,
	output logic done_o,
	output logic [DATA_W-1:0] rdata_o,
	output logic bus_reference_clock_out_o,
	output logic rd_b_o,
	output logic wr_b_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic [DATA_W-1:0] data_pin_o,
	output logic data_pin_oe_o
);
	import ext_bus_ready_pkg::*;

	// ==========================================================
	// Elaboration checks
	if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must be 1 to 32");
	end
	if (DATA_W < 1 || DATA_W > 32) begin : g_bad_data
		$error("DATA_W must be 1 to 32");
	end

	cycle_state_t state_q;
	logic ref_q;
	logic tick;
	logic write_q;
	logic async_q;
	logic pol_q;
	logic [ACC_LEN_W-1:0] len_q;
	logic [ACC_LEN_W-1:0] cnt_q;
	logic access_last;
	logic rdy_raw;
	logic sync1_q;
	logic sync2_q;
	logic rdy_sample;
	logic take;
	logic finish;
	logic done_q;
	logic [DATA_W-1:0] rdata_q;
	logic rd_b_q;
	logic wr_b_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic oe_q;

	// Clamp a requested access length into the legal range
	function automatic logic [ACC_LEN_W-1:0] clamp_len(input logic [ACC_LEN_W-1:0] len);
		if (len < ACC_LEN_MIN) begin
			return ACC_LEN_MIN;
		end
		if (len > ACC_LEN_MAX) begin
			return ACC_LEN_MAX;
		end
		return len;
	endfunction

	// ==========================================================
	// Bus reference clock: system clock divided by two
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ref_q <= RST_REF_CLK;
		end else begin
			ref_q <= ~ref_q;
		end
	end
	assign tick = ref_q; // Bus phases advance where reference clock falls

	// ==========================================================
	// Ready conditioning
	// Polarity correction ahead of both sample paths
	assign rdy_raw = pol_q ? ready_i : ~ready_i;

	// Two-flop synchroniser, first flop feeds only the second
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= rdy_raw;
			sync2_q <= sync1_q;
		end
	end

	// Sync mode reads the pin directly, async mode the synchronised copy
	assign rdy_sample = async_q ? sync2_q : rdy_raw;

	// ==========================================================
	// Cycle sequencing
	assign req_ready_o = (state_q == ST_IDLE) && tick;
	assign take = req_ready_o && start_i;
	assign access_last = (cnt_q == len_q - 6'h01);
	// Ready counts only at the access end (sync) or in ready waits
	assign finish = tick && (((state_q == ST_ACCESS) && access_last && !async_q && rdy_raw)
		|| ((state_q == ST_RDY_WAIT) && rdy_sample));
	assign busy_o = (state_q != ST_IDLE);

	// Cycle configuration latched when a request is taken
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			write_q <= 1'b0;
			async_q <= RST_ASYNC;
			pol_q <= RST_POL;
			len_q <= ACC_LEN_MIN;
			addr_q <= '0;
			wdata_q <= '0;
		end else if (take) begin
			write_q <= write_i;
			async_q <= ready_async_i;
			pol_q <= ready_active_high_i;
			len_q <= clamp_len(access_phase_length_i);
			addr_q <= addr_i;
			wdata_q <= wdata_i;
		end
	end

	// Access phase counter in bus clock periods
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= '0;
		end else if (take) begin
			cnt_q <= '0;
		end else if (tick && (state_q == ST_ACCESS) && !access_last) begin
			cnt_q <= cnt_q + 6'h01;
		end
	end

	// State machine
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (take) begin
						state_q <= ST_ACCESS;
					end
				end
				ST_ACCESS: begin
					if (finish) begin
						state_q <= ST_IDLE;
					end else if (tick && access_last) begin
						state_q <= ST_RDY_WAIT;
					end
				end
				ST_RDY_WAIT: begin
					if (finish) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Pins and read data
	// The direction's strobe falls at cycle start; both are high again from the terminating edge
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_b_q <= RST_STROBE_B;
			wr_b_q <= RST_STROBE_B;
			oe_q <= 1'b0;
		end else if (take) begin
			rd_b_q <= write_i;
			wr_b_q <= ~write_i;
			oe_q <= write_i;
		end else if (finish) begin
			rd_b_q <= RST_STROBE_B;
			wr_b_q <= RST_STROBE_B;
			oe_q <= 1'b0;
		end
	end

	// Read data captured on the strobe-release edge
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q <= '0;
		end else if (finish && !write_q) begin
			rdata_q <= data_pin_i;
		end
	end

	// Completion pulse
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			done_q <= 1'b0;
		end else begin
			done_q <= finish;
		end
	end

	assign done_o = done_q;
	assign rdata_o = rdata_q;
	assign bus_reference_clock_out_o = ref_q;
	assign rd_b_o = rd_b_q;
	assign wr_b_o = wr_b_q;
	assign addr_o = addr_q;
	assign data_pin_o = wdata_q;
	assign data_pin_oe_o = oe_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	idle_strobes_a: assert property ((state_q == ST_IDLE) |-> (rd_b_o && wr_b_o))
		else $error("strobe active while idle");
	end_cycle_a: assert property (finish |=> (done_o && (state_q == ST_IDLE) && rd_b_o && wr_b_o))
		else $error("cycle not ended after active ready");
	early_ready_a: assert property ((state_q == ST_ACCESS) && !access_last |=> (state_q != ST_IDLE))
		else $error("ready used before access phase ended");
	async_wait_a: assert property ((state_q == ST_ACCESS) && async_q |=> (state_q != ST_IDLE))
		else $error("async cycle ended without wait state");
	sync_fast_a: assert property (tick && (state_q == ST_ACCESS) && access_last && !async_q && rdy_raw
		|=> (state_q == ST_IDLE))
		else $error("sync ready at first sample did not end cycle");
	wait_insert_a: assert property (tick && (state_q == ST_RDY_WAIT) && !rdy_sample
		|=> (state_q == ST_RDY_WAIT) ##1 (state_q == ST_RDY_WAIT))
		else $error("inactive ready did not add a wait state");
	read_capture_a: assert property (finish && !write_q |=> (rdata_o == $past(data_pin_i)) && rd_b_o)
		else $error("read data not captured at strobe release");
	sync_chain_a: assert property ($past(rst_b_i, 2) |-> (sync2_q == $past(rdy_raw, 2)))
		else $error("synchroniser depth wrong");
	polarity_use_a: assert property (tick && (state_q == ST_RDY_WAIT) && !async_q && (ready_i == pol_q)
		|=> (state_q == ST_IDLE))
		else $error("ready polarity not honoured");
	phase_len_a: assert property ((state_q == ST_ACCESS) |-> (cnt_q < len_q))
		else $error("access counter past programmed length");
	async_late_a: assert property ((state_q == ST_RDY_WAIT) && async_q && tick && !sync2_q |=> busy_o)
		else $error("async cycle ended on unsynchronised ready");

	sync_zero_c: cover property (take ##[1:70] (finish && (state_q == ST_ACCESS)));
	async_end_c: cover property ((state_q == ST_RDY_WAIT) && async_q && finish);
	write_wait_c: cover property ((state_q == ST_RDY_WAIT) && write_q && tick && !rdy_sample ##2 finish);
endmodule

/* testbench/ext_mem_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Far-side memory that stretches each cycle with ready
module ext_mem_model (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic rd_b_i,
	input wire logic wr_b_i,
	input wire logic [23:0] addr_i,
	input wire logic [3:0] delay_i,
	input wire logic active_high_i,
	output logic ready_o,
	output logic [15:0] data_o
);
	logic [3:0] cnt_q;
	logic on_q;
	logic [3:0] dly_q;
	logic pol_q;

	// Count strobe cycles, raise ready after the chosen delay, drop it when the strobe ends
	// Delay and polarity are latched only between cycles, so a new setting cannot hit a running cycle
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= 4'h0;
			on_q <= 1'b0;
			dly_q <= 4'h0;
			pol_q <= 1'b1;
		end else if (rd_b_i && wr_b_i) begin
			cnt_q <= 4'h0;
			on_q <= 1'b0;
			dly_q <= delay_i;
			pol_q <= active_high_i;
		end else if (cnt_q == dly_q) begin
			on_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// Inactive ready is the inverse level; data is inverted while not read
	assign ready_o = on_q ~^ pol_q;
	assign data_o = {16{rd_b_i}} ^ addr_i[15:0] ^ 16'h5A5A;
endmodule

/* testbench/ext_bus_ready_wait_control_bench.sv */
`timescale 1ns/1ps
module ext_bus_ready_wait_control_bench;
	import ext_bus_ready_pkg::*;
	typedef struct {int take; int lat; logic wr; logic [23:0] addr; logic [15:0] data;} note_t;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic start_i = 1'b0;
	logic write_i = 1'b0;
	logic [23:0] addr_i = 24'h000000;
	logic [15:0] wdata_i = 16'h0000;
	logic [5:0] len_i = 6'h01;
	logic async_i = 1'b0;
	logic pol_i = 1'b1;
	logic [3:0] delay_i = 4'h0;
	logic ready_i;
	logic [15:0] data_in;
	logic req_ready_o, busy_o, done_o, ref_o, rd_b_o, wr_b_o, oe_o;
	logic [15:0] rdata_o, data_out;
	logic [23:0] addr_o;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	integer seed;
	int i;
	logic [31:0] r;
	note_t notes[$];
	note_t nt;

	// ==========================================================
	// Clock and design
	always #2.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) cyc <= cyc + 1;

	ext_bus_ready_wait_control DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .start_i(start_i),
		.write_i(write_i), .addr_i(addr_i), .wdata_i(wdata_i), .access_phase_length_i(len_i),
		.ready_async_i(async_i), .ready_active_high_i(pol_i), .ready_i(ready_i), .data_pin_i(data_in),
		.req_ready_o(req_ready_o), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o),
		.bus_reference_clock_out_o(ref_o), .rd_b_o(rd_b_o), .wr_b_o(wr_b_o), .addr_o(addr_o),
		.data_pin_o(data_out), .data_pin_oe_o(oe_o));

	ext_mem_model mem (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .rd_b_i(rd_b_o), .wr_b_i(wr_b_o),
		.addr_i(addr_o), .delay_i(delay_i), .active_high_i(pol_i), .ready_o(ready_i), .data_o(data_in));

	// ==========================================================
	// Tasks
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic conclude();
		if (err_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Issue one cycle and note its expected length and data
	task automatic do_op(input logic [5:0] len, input logic [3:0] d, input logic a, input logic p, input logic w);
		int le;
		int j;
		int k;
		logic [23:0] ad;
		logic [15:0] wd;
		le = (len == 6'h00) ? 1 : (len > 6'h20) ? 32 : len;
		j = (2 + d > 2 * le) ? (3 + d - 2 * le) / 2 : 0;
		ad = $random(seed);
		wd = $random(seed);
		@(posedge clk_sys_i);
		start_i <= 1'b1;
		write_i <= w;
		addr_i <= ad;
		wdata_i <= wd;
		len_i <= len;
		async_i <= a;
		pol_i <= p;
		delay_i <= d;
		k = 0;
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (req_ready_o !== 1'b1 && k < 300);
		start_i <= 1'b0;
		notes.push_back('{cyc, 2 * le + 2 * j + 2 * a + 1, w, ad, wd});
	endtask

	// ==========================================================
	// Result watcher
	always @(posedge clk_sys_i) begin
		// Strobe and drive enable follow the direction of the running cycle
		if (rst_b_i && busy_o === 1'b1 && notes.size() != 0) begin
			chk("strobe pair", {notes[0].wr, ~notes[0].wr}, {rd_b_o, wr_b_o});
			chk("drive enable", notes[0].wr, oe_o);
		end
		if (rst_b_i && done_o === 1'b1) begin
			if (notes.size() == 0) begin
				chk("unexpected done", 32'h0, 32'h1);
			end else begin
				nt = notes.pop_front();
				chk("latency", nt.lat, cyc - nt.take);
				chk("strobes", 32'h3, {rd_b_o, wr_b_o});
				chk("busy", 32'h0, busy_o);
				chk("drive enable", 32'h0, oe_o);
				chk("reference clock", 32'h0, ref_o);
				chk("addr", nt.addr, addr_o);
				if (nt.wr) begin
					chk("wdata", nt.data, data_out);
				end else begin
					chk("rdata", nt.addr[15:0] ^ 16'h5A5A, rdata_o);
				end
			end
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		seed = 32'hf1bc;
		repeat (16) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		do_op(6'h21, 4'h0, 1'b0, 1'b1, 1'b0);
		do_op(6'h00, 4'h9, 1'b1, 1'b0, 1'b1);
		for (i = 0; i < 40; i++) begin
			r = $random(seed);
			do_op({3'h0, r[2:0]}, r[6:3] % 4'hA, r[7], r[8], r[9]);
		end
		repeat (100) @(posedge clk_sys_i);
		chk("pending", 32'h0, notes.size());
		conclude();
	end

	// Watchdog
	initial begin
		#300000;
		err_count++;
		conclude();
	end
endmodule
